// ==== design/amcc_defines.svh ====
// Control word layout, reset values and sequencing counts for mode and calibration control
`ifndef AMCC_DEFINES_SVH
`define AMCC_DEFINES_SVH

`define AMCC_WORD_W        24
`define AMCC_CNT_W         5
`define AMCC_SHORT_LEN     5'd16
`define AMCC_LONG_LEN      5'd24
`define AMCC_MODE_HI       23
`define AMCC_MODE_LO       21
`define AMCC_GAIN_HI       20
`define AMCC_GAIN_LO       18
`define AMCC_CHAN_BIT      17
`define AMCC_PDOWN_BIT     16
`define AMCC_WLEN_BIT      15
`define AMCC_RTD_BIT       14
`define AMCC_BURN_BIT      13
`define AMCC_UNIPOLAR_BIT  12
`define AMCC_FILT_HI       11
`define AMCC_FILT_LO       0
`define AMCC_CTRL_RST      24'h000000
`define AMCC_ZERO_COEF_RST 24'h000000
`define AMCC_FULL_COEF_RST 24'h800000
`define AMCC_BG_SLOTS      6
`define AMCC_BG_CAL_SLOTS  3'h2
`define AMCC_SLOT_W        3

`endif

// ==== design/amcc_pkg.sv ====
// Types shared by the mode and calibration control block
`default_nettype none
package amcc_pkg;

    typedef enum logic [2:0] {
        AMCC_MODE_NORMAL     = 3'h0,
        AMCC_MODE_SELF_CAL   = 3'h1,
        AMCC_MODE_SYS_ZERO   = 3'h2,
        AMCC_MODE_SYS_FULL   = 3'h3,
        AMCC_MODE_SYS_OFFSET = 3'h4,
        AMCC_MODE_BACKGROUND = 3'h5,
        AMCC_MODE_ZERO_COEF  = 3'h6,
        AMCC_MODE_FULL_COEF  = 3'h7
    } amcc_mode_t;

    typedef enum logic [3:0] {
        AMCC_ST_NORMAL     = 4'h1,
        AMCC_ST_CAL_ZERO   = 4'h2,
        AMCC_ST_CAL_FULL   = 4'h4,
        AMCC_ST_BACKGROUND = 4'h8
    } amcc_state_t;

endpackage : amcc_pkg
`default_nettype wire

// ==== design/amcc_serial_port.sv ====
// Framed serial port: pin synchronisers, 24-bit write capture and word readout
`timescale 1ns/1ps
`include "amcc_defines.svh"
`default_nettype none
module amcc_serial_port #(
    parameter int WORD_W = `AMCC_WORD_W
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_sclk,
    input  wire logic              i_sdata_in,
    input  wire logic              i_transmit_frame_n,
    input  wire logic              i_receive_frame_n,
    input  wire logic              i_register_select,
    input  wire logic [WORD_W-1:0] i_rd_word,
    input  wire logic              i_rd_len24,
    input  wire logic              i_rd_enable,
    input  wire logic              i_rd_is_data,
    output logic                   o_sel,
    output logic                   o_wr_done,
    output logic [WORD_W-1:0]      o_wr_word,
    output logic                   o_wr_sel,
    output logic                   o_data_rd_done,
    output logic                   o_sdata_out,
    output logic                   o_sdata_oe_n
);
    import amcc_pkg::*;

    // Order: sclk, sdata, transmit frame, receive frame, register select
    logic [4:0]              sync1_reg;
    logic [4:0]              sync2_reg;
    logic [2:0]              prev_reg;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    tx_start;
    logic                    tx_end;
    logic                    rx_start;
    logic                    rx_end;
    logic [`AMCC_CNT_W-1:0]  wr_cnt_reg;
    logic [WORD_W-1:0]       wr_shift_reg;
    logic [`AMCC_CNT_W-1:0]  rd_cnt_reg;
    logic [`AMCC_CNT_W-1:0]  rd_len_reg;
    logic [WORD_W-1:0]       rd_shift_reg;
    logic                    rd_active_reg;
    logic                    rd_data_reg;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            // Idle pin levels, so no false edge follows reset
            sync1_reg <= 5'h06;
            sync2_reg <= 5'h06;
            prev_reg  <= 3'h3;
        end
        else
        begin
            sync1_reg <= {i_sclk, i_sdata_in, i_transmit_frame_n, i_receive_frame_n, i_register_select};
            sync2_reg <= sync1_reg;
            prev_reg  <= {sync2_reg[4], sync2_reg[2], sync2_reg[1]};
        end
    end

    assign sclk_rise = sync2_reg[4] && !prev_reg[2];
    assign sclk_fall = !sync2_reg[4] && prev_reg[2];
    assign tx_start  = !sync2_reg[2] && prev_reg[1];
    assign tx_end    = sync2_reg[2] && !prev_reg[1];
    assign rx_start  = !sync2_reg[1] && prev_reg[0];
    assign rx_end    = sync2_reg[1] && !prev_reg[0];
    assign o_sel     = sync2_reg[0];

    // Write frame: clocks past the last bit are dropped, short frames never load
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_cnt_reg   <= '0;
            wr_shift_reg <= '0;
            o_wr_done    <= 1'b0;
            o_wr_word    <= '0;
            o_wr_sel     <= 1'b0;
        end
        else
        begin
            o_wr_done <= 1'b0;
            if (tx_start)
            begin
                wr_cnt_reg <= '0;
                o_wr_sel   <= sync2_reg[0];
            end
            else if (!sync2_reg[2] && sclk_rise && wr_cnt_reg != `AMCC_LONG_LEN)
            begin
                wr_shift_reg <= {wr_shift_reg[WORD_W-2:0], sync2_reg[3]};
                wr_cnt_reg   <= wr_cnt_reg + 5'd1;
            end
            else if (tx_end && wr_cnt_reg == `AMCC_LONG_LEN)
            begin
                o_wr_done <= 1'b1;
                o_wr_word <= wr_shift_reg;
            end
        end
    end

    // Read frame: MSB drives at frame start, next bit on each falling sclk
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_cnt_reg     <= '0;
            rd_len_reg     <= `AMCC_LONG_LEN;
            rd_shift_reg   <= '0;
            rd_active_reg  <= 1'b0;
            rd_data_reg    <= 1'b0;
            o_data_rd_done <= 1'b0;
        end
        else
        begin
            o_data_rd_done <= 1'b0;
            if (rx_start)
            begin
                rd_active_reg <= i_rd_enable;
                rd_shift_reg  <= i_rd_word;
                rd_len_reg    <= i_rd_len24 ? `AMCC_LONG_LEN : `AMCC_SHORT_LEN;
                rd_data_reg   <= i_rd_is_data;
                rd_cnt_reg    <= '0;
            end
            else if (rx_end)
            begin
                rd_active_reg <= 1'b0;
            end
            else if (rd_active_reg && sclk_fall)
            begin
                rd_shift_reg <= {rd_shift_reg[WORD_W-2:0], 1'b0};
            end
            else if (rd_active_reg && sclk_rise)
            begin
                rd_cnt_reg <= rd_cnt_reg + 5'd1;
                if (rd_cnt_reg + 5'd1 == rd_len_reg)
                begin
                    rd_active_reg  <= 1'b0;
                    o_data_rd_done <= rd_data_reg;
                end
            end
        end
    end

    assign o_sdata_out  = rd_shift_reg[WORD_W-1];
    assign o_sdata_oe_n = !rd_active_reg;

endmodule : amcc_serial_port
`default_nettype wire

// ==== design/amcc_top.sv ====
// Mode decoder and calibration sequencer driven by the 24-bit control word
`timescale 1ns/1ps
`include "amcc_defines.svh"
`default_nettype none
module amcc_top #(
    parameter int WORD_W   = `AMCC_WORD_W,
    parameter int BG_SLOTS = `AMCC_BG_SLOTS
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_sclk,
    input  wire logic                 i_sdata_in,
    input  wire logic                 i_transmit_frame_n,
    input  wire logic                 i_receive_frame_n,
    input  wire logic                 i_register_select,
    input  wire logic                 i_conv_done,
    input  wire logic [WORD_W-1:0]    i_conv_data,
    input  wire logic                 i_cal_done,
    input  wire logic [WORD_W-1:0]    i_cal_value,
    output logic                      o_sdata_out,
    output logic                      o_sdata_oe_n,
    output logic                      o_result_ready_n,
    output amcc_pkg::amcc_mode_t      o_op_mode,
    output logic                      o_cal_active,
    output logic                      o_cal_full_scale,
    output logic                      o_cal_internal,
    output logic                      o_cal_channel,
    output logic [WORD_W-1:0]         o_zero_coef,
    output logic [WORD_W-1:0]         o_full_coef,
    output logic [2:0]                o_gain_code,
    output logic                      o_channel_select,
    output logic                      o_power_down_select,
    output logic                      o_output_word_length,
    output logic                      o_rtd_current_on,
    output logic                      o_burnout_current_on,
    output logic                      o_unipolar_select,
    output logic [11:0]               o_filter_code
);
    import amcc_pkg::*;

    logic [WORD_W-1:0]        ctrl_reg;
    logic [WORD_W-1:0]        result_reg;
    logic [WORD_W-1:0]        zero_coef_reg [2];
    logic [WORD_W-1:0]        full_coef_reg [2];
    amcc_state_t              state_reg;
    logic [`AMCC_SLOT_W-1:0]  slot_reg;
    logic                     cal_chan_reg;
    logic                     zero_int_reg;
    logic                     full_int_reg;
    logic                     two_step_reg;
    logic                     ready_n_reg;
    amcc_mode_t               mode;
    amcc_mode_t               new_mode;
    logic                     sel;
    logic                     wr_done;
    logic [WORD_W-1:0]        wr_word;
    logic                     wr_sel;
    logic                     data_rd_done;
    logic                     ctrl_write;
    logic                     cal_finish;
    logic                     cal_store;
    logic                     bg_cal_slot;
    logic                     publish;
    logic [1:0]               coef_sel;
    logic [WORD_W-1:0]        rd_word;

    // Bit 1: a coefficient is mapped to the data access; bit 0: it is the full-scale one
    function automatic logic [1:0] coef_target(input amcc_mode_t m);
        coef_target = {m == AMCC_MODE_ZERO_COEF || m == AMCC_MODE_FULL_COEF, m == AMCC_MODE_FULL_COEF};
    endfunction : coef_target

    amcc_serial_port #(
        .WORD_W (WORD_W)
    ) u_port (
        .i_clock            (i_clock),
        .i_rst_n            (i_rst_n),
        .i_sclk             (i_sclk),
        .i_sdata_in         (i_sdata_in),
        .i_transmit_frame_n (i_transmit_frame_n),
        .i_receive_frame_n  (i_receive_frame_n),
        .i_register_select  (i_register_select),
        .i_rd_word          (rd_word),
        .i_rd_len24         (!sel || coef_sel[1] || ctrl_reg[`AMCC_WLEN_BIT]),
        .i_rd_enable        (!sel || coef_sel[1] || !ready_n_reg),
        .i_rd_is_data       (sel && !coef_sel[1]),
        .o_sel              (sel),
        .o_wr_done          (wr_done),
        .o_wr_word          (wr_word),
        .o_wr_sel           (wr_sel),
        .o_data_rd_done     (data_rd_done),
        .o_sdata_out        (o_sdata_out),
        .o_sdata_oe_n       (o_sdata_oe_n)
    );

    assign mode        = amcc_mode_t'(ctrl_reg[`AMCC_MODE_HI:`AMCC_MODE_LO]);
    assign new_mode    = amcc_mode_t'(wr_word[`AMCC_MODE_HI:`AMCC_MODE_LO]);
    assign ctrl_write  = wr_done && !wr_sel;
    assign coef_sel    = coef_target(mode);
    assign bg_cal_slot = (state_reg == AMCC_ST_BACKGROUND) && (slot_reg < `AMCC_BG_CAL_SLOTS);
    assign cal_finish  = i_cal_done && !ctrl_write &&
                         ((state_reg == AMCC_ST_CAL_ZERO && !two_step_reg) || state_reg == AMCC_ST_CAL_FULL);

    // Data access target; coefficient reads follow the channel bit
    always_comb
    begin
        if (!sel)
            rd_word = ctrl_reg;
        else if (coef_sel == 2'b11)
            rd_word = full_coef_reg[ctrl_reg[`AMCC_CHAN_BIT]];
        else if (coef_sel == 2'b10)
            rd_word = zero_coef_reg[ctrl_reg[`AMCC_CHAN_BIT]];
        else
            rd_word = result_reg;
    end

    // A fresh host word beats the automatic mode clear in the same cycle
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl_reg <= `AMCC_CTRL_RST;
        else if (ctrl_write)
            ctrl_reg <= wr_word;
        else if (cal_finish)
            ctrl_reg[`AMCC_MODE_HI:`AMCC_MODE_LO] <= AMCC_MODE_NORMAL;
    end

    // Calibration sequencer; rewriting a calibration code restarts it
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg    <= AMCC_ST_NORMAL;
            slot_reg     <= '0;
            cal_chan_reg <= 1'b0;
            zero_int_reg <= 1'b1;
            full_int_reg <= 1'b1;
            two_step_reg <= 1'b0;
        end
        else if (ctrl_write)
        begin
            cal_chan_reg <= wr_word[`AMCC_CHAN_BIT];
            slot_reg     <= '0;
            unique case (new_mode)
                AMCC_MODE_SELF_CAL:
                begin
                    state_reg    <= AMCC_ST_CAL_ZERO;
                    zero_int_reg <= 1'b1;
                    full_int_reg <= 1'b1;
                    two_step_reg <= 1'b1;
                end
                AMCC_MODE_SYS_ZERO:
                begin
                    state_reg    <= AMCC_ST_CAL_ZERO;
                    zero_int_reg <= 1'b0;
                    two_step_reg <= 1'b0;
                end
                AMCC_MODE_SYS_FULL:
                begin
                    state_reg    <= AMCC_ST_CAL_FULL;
                    full_int_reg <= 1'b0;
                    two_step_reg <= 1'b0;
                end
                AMCC_MODE_SYS_OFFSET:
                begin
                    state_reg    <= AMCC_ST_CAL_ZERO;
                    zero_int_reg <= 1'b0;
                    full_int_reg <= 1'b1;
                    two_step_reg <= 1'b1;
                end
                AMCC_MODE_BACKGROUND:
                    state_reg <= AMCC_ST_BACKGROUND;
                AMCC_MODE_NORMAL, AMCC_MODE_ZERO_COEF, AMCC_MODE_FULL_COEF:
                    state_reg <= AMCC_ST_NORMAL;
            endcase
        end
        else
        begin
            unique case (state_reg)
                AMCC_ST_NORMAL:
                    state_reg <= AMCC_ST_NORMAL;
                AMCC_ST_CAL_ZERO:
                    if (i_cal_done)
                        state_reg <= two_step_reg ? AMCC_ST_CAL_FULL : AMCC_ST_NORMAL;
                AMCC_ST_CAL_FULL:
                    if (i_cal_done)
                        state_reg <= AMCC_ST_NORMAL;
                AMCC_ST_BACKGROUND:
                    // Two self-cal slots then the conversions: one word out of every six steps
                    if (bg_cal_slot ? i_cal_done : i_conv_done)
                        slot_reg <= (slot_reg == `AMCC_SLOT_W'(BG_SLOTS - 1)) ? '0 : slot_reg + 3'h1;
                default:
                    state_reg <= AMCC_ST_NORMAL;
            endcase
        end
    end

    assign o_cal_active     = (state_reg == AMCC_ST_CAL_ZERO) || (state_reg == AMCC_ST_CAL_FULL) || bg_cal_slot;
    assign o_cal_full_scale = (state_reg == AMCC_ST_CAL_FULL) || (bg_cal_slot && slot_reg[0]);
    assign o_cal_internal   = (state_reg == AMCC_ST_CAL_ZERO) ? zero_int_reg :
                              (state_reg == AMCC_ST_CAL_FULL) ? full_int_reg : 1'b1;
    assign o_cal_channel    = (state_reg == AMCC_ST_BACKGROUND) ? ctrl_reg[`AMCC_CHAN_BIT] : cal_chan_reg;
    assign cal_store        = i_cal_done && o_cal_active;

    // Per-channel coefficient store: calibration results and full 24-bit host writes
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_coef
        always_ff @(posedge i_clock or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                zero_coef_reg[ch] <= `AMCC_ZERO_COEF_RST;
                full_coef_reg[ch] <= `AMCC_FULL_COEF_RST;
            end
            else if (cal_store && o_cal_channel == 1'(ch))
            begin
                if (o_cal_full_scale)
                    full_coef_reg[ch] <= i_cal_value;
                else
                    zero_coef_reg[ch] <= i_cal_value;
            end
            else if (wr_done && wr_sel && coef_sel[1] && ctrl_reg[`AMCC_CHAN_BIT] == 1'(ch))
            begin
                if (coef_sel[0])
                    full_coef_reg[ch] <= wr_word;
                else
                    zero_coef_reg[ch] <= wr_word;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_zero_coef <= `AMCC_ZERO_COEF_RST;
            o_full_coef <= `AMCC_FULL_COEF_RST;
        end
        else
        begin
            o_zero_coef <= zero_coef_reg[o_cal_channel];
            o_full_coef <= full_coef_reg[o_cal_channel];
        end
    end

    // Results are held back during calibration so the first word after it is valid
    assign publish = i_conv_done && !ctrl_write &&
                     ((state_reg == AMCC_ST_NORMAL) ||
                      (state_reg == AMCC_ST_BACKGROUND && slot_reg == `AMCC_SLOT_W'(BG_SLOTS - 1)));

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            result_reg  <= '0;
            ready_n_reg <= 1'b1;
        end
        else if (publish)
        begin
            result_reg  <= i_conv_data;
            ready_n_reg <= 1'b0;
        end
        else if (data_rd_done || (ctrl_write && new_mode != AMCC_MODE_NORMAL &&
                                  new_mode != AMCC_MODE_ZERO_COEF && new_mode != AMCC_MODE_FULL_COEF))
        begin
            ready_n_reg <= 1'b1;
        end
    end

    assign o_result_ready_n     = ready_n_reg;
    assign o_op_mode            = mode;
    assign o_gain_code          = ctrl_reg[`AMCC_GAIN_HI:`AMCC_GAIN_LO];
    assign o_channel_select     = ctrl_reg[`AMCC_CHAN_BIT];
    assign o_power_down_select  = ctrl_reg[`AMCC_PDOWN_BIT];
    assign o_output_word_length = ctrl_reg[`AMCC_WLEN_BIT];
    assign o_rtd_current_on     = ctrl_reg[`AMCC_RTD_BIT];
    assign o_burnout_current_on = ctrl_reg[`AMCC_BURN_BIT];
    assign o_unipolar_select    = ctrl_reg[`AMCC_UNIPOLAR_BIT];
    // Passed through as written; a set top bit is the host's fault
    assign o_filter_code        = ctrl_reg[`AMCC_FILT_HI:`AMCC_FILT_LO];

endmodule : amcc_top
`default_nettype wire

// ==== sim/amcc_chk.sv ====
// Port checker for the mode and calibration control block
`timescale 1ns/1ps
`default_nettype none
module amcc_chk (
    input wire logic                 i_clock,
    input wire logic                 i_rst_n,
    input wire logic                 i_conv_done,
    input wire logic                 i_cal_done,
    input wire logic                 o_result_ready_n,
    input wire amcc_pkg::amcc_mode_t o_op_mode,
    input wire logic                 o_cal_active,
    input wire logic                 o_cal_full_scale,
    input wire logic                 o_cal_internal
);
    import amcc_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic step_end;
    assign step_end = i_cal_done && o_cal_active && o_op_mode != AMCC_MODE_BACKGROUND
                      && (o_cal_full_scale || o_op_mode == AMCC_MODE_SYS_ZERO);
    chk_self_src: assert property (o_cal_active && o_op_mode == AMCC_MODE_SELF_CAL |-> o_cal_internal)
        else $error("self cal source wrong");
    chk_sys_zero: assert property (o_cal_active && o_op_mode == AMCC_MODE_SYS_ZERO
        |-> !o_cal_full_scale && !o_cal_internal)
        else $error("system zero step wrong");
    chk_sys_full: assert property (o_cal_active && o_op_mode == AMCC_MODE_SYS_FULL
        |-> o_cal_full_scale && !o_cal_internal)
        else $error("system full step wrong");
    chk_offset_src: assert property (o_cal_active && o_op_mode == AMCC_MODE_SYS_OFFSET
        |-> o_cal_internal == o_cal_full_scale)
        else $error("offset cal source wrong");
    chk_step_clear: assert property (step_end
        |=> o_op_mode == AMCC_MODE_NORMAL && !o_cal_active)
        else $error("mode not cleared after step");
    chk_bg_keep: assert property (o_op_mode == AMCC_MODE_BACKGROUND && (i_cal_done || i_conv_done)
        |=> $stable(o_op_mode))
        else $error("background mode lost");
    chk_cal_hide: assert property (o_cal_active && i_conv_done && o_result_ready_n |=> o_result_ready_n)
        else $error("result published during cal");
    chk_normal_publish: assert property (o_op_mode == AMCC_MODE_NORMAL && !o_cal_active && i_conv_done
        |=> !o_result_ready_n)
        else $error("result not published");
    // Background slot 0 follows a published word, so ready may be low there
    chk_enter_ready: assert property ($rose(o_cal_active) && o_op_mode != AMCC_MODE_BACKGROUND
        |-> ##[0:1] o_result_ready_n)
        else $error("ready low entering cal");
    cover property (o_op_mode == AMCC_MODE_BACKGROUND && i_cal_done);
    cover property (o_op_mode == AMCC_MODE_SYS_OFFSET && o_cal_active && o_cal_full_scale);
    cover property ($fell(o_result_ready_n));
endmodule : amcc_chk
bind amcc_top amcc_chk u_amcc_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_conv_done(i_conv_done),
    .i_cal_done(i_cal_done), .o_result_ready_n(o_result_ready_n), .o_op_mode(o_op_mode),
    .o_cal_active(o_cal_active), .o_cal_full_scale(o_cal_full_scale), .o_cal_internal(o_cal_internal));
`default_nettype wire

// ==== sim/amcc_host.sv ====
// Host controller model on the framed serial port
`timescale 1ns/1ps
`default_nettype none
module amcc_host (
    input  wire logic i_clock,
    input  wire logic i_line,
    output logic      o_sclk,
    output logic      o_sdata,
    output logic      o_transmit_frame_n,
    output logic      o_receive_frame_n,
    output logic      o_register_select
);
    initial
    begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_transmit_frame_n = 1'b1;
        o_receive_frame_n = 1'b1;
        o_register_select = 1'b0;
    end
    // Serial clock stays low outside frames; while reading, the host's own line toggles so a stale level never passes
    task automatic xfer(input logic rd, input logic sel, input int n, input logic [23:0] w, output logic [23:0] q);
        q = 24'h000000;
        @(negedge i_clock);
        o_register_select = sel;
        o_receive_frame_n = ~rd;
        o_transmit_frame_n = rd;
        for (int i = 0; i < n; i++)
        begin
            o_sdata = (rd || i > 23) ? ~o_sdata : w[23-i];
            repeat (8) @(negedge i_clock);
            o_sclk = 1'b1;
            q = {q[22:0], i_line};
            repeat (8) @(negedge i_clock);
            o_sclk = 1'b0;
        end
        repeat (8) @(negedge i_clock);
        o_transmit_frame_n = 1'b1;
        o_receive_frame_n = 1'b1;
        repeat (8) @(negedge i_clock);
    endtask : xfer
endmodule : amcc_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the mode and calibration control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
    import amcc_pkg::*;
    logic       clock = 1'b0, rst_n = 1'b0, sclk, host_sd, tfs_n, rfs_n, rsel, oe_n, sd_out, ready_n;
    logic       conv_done = 1'b0, cal_done = 1'b0, cal_on, cal_full, cal_int, cal_ch;
    logic [23:0] eng_data = 24'h000000, q, zero_coef, full_coef;
    logic [20:0] fields;
    amcc_mode_t mode;
    int         bad_count = 0, tests_run = 0, k;
    wire        line = oe_n ? host_sd : sd_out;
    always #4 clock = ~clock;
    amcc_top u_amcc_top (.i_clock(clock), .i_rst_n(rst_n), .i_sclk(sclk), .i_sdata_in(line),
        .i_transmit_frame_n(tfs_n), .i_receive_frame_n(rfs_n), .i_register_select(rsel),
        .i_conv_done(conv_done), .i_conv_data(eng_data), .i_cal_done(cal_done), .i_cal_value(eng_data),
        .o_sdata_out(sd_out), .o_sdata_oe_n(oe_n), .o_result_ready_n(ready_n), .o_op_mode(mode),
        .o_cal_active(cal_on), .o_cal_full_scale(cal_full), .o_cal_internal(cal_int), .o_cal_channel(cal_ch),
        .o_zero_coef(zero_coef), .o_full_coef(full_coef), .o_gain_code(fields[20:18]),
        .o_channel_select(fields[17]), .o_power_down_select(fields[16]), .o_output_word_length(fields[15]),
        .o_rtd_current_on(fields[14]), .o_burnout_current_on(fields[13]), .o_unipolar_select(fields[12]),
        .o_filter_code(fields[11:0]));
    amcc_host u_amcc_host (.i_clock(clock), .i_line(line), .o_sclk(sclk), .o_sdata(host_sd),
        .o_transmit_frame_n(tfs_n), .o_receive_frame_n(rfs_n), .o_register_select(rsel));
    task automatic wr(input logic sel, input int n, input logic [23:0] w);
        u_amcc_host.xfer(1'b0, sel, n, w, q);
    endtask : wr
    task automatic rd(input logic sel, input int n);
        u_amcc_host.xfer(1'b1, sel, n, 24'h000000, q);
    endtask : rd
    // One engine pulse, then a quiet gap so the registered coefficients settle
    task automatic eng(input logic cal, input logic [23:0] v);
        @(negedge clock);
        cal_done = cal;
        conv_done = ~cal;
        eng_data = v;
        @(negedge clock);
        cal_done = 1'b0;
        conv_done = 1'b0;
        repeat (2) @(negedge clock);
    endtask : eng
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic t_ctrl;
        `CHK("mode", AMCC_MODE_NORMAL, mode)
        rd(1'b0, 24);
        `CHK("ctrl reset", 24'h000000, q)
        wr(1'b0, 24, 24'h1d5123);
        `CHK("fields", 21'h1d5123, fields)
        rd(1'b0, 24);
        `CHK("ctrl read", 24'h1d5123, q)
        wr(1'b0, 26, 24'h0a0456);
        `CHK("long write", 21'h0a0456, fields)
        wr(1'b0, 16, 24'h1f0789);
        `CHK("short write", 21'h0a0456, fields)
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_coef;
        wr(1'b0, 24, 24'hc00000);
        wr(1'b1, 24, 24'h123456);
        rd(1'b1, 24);
        `CHK("zero read", 24'h123456, q)
        `CHK("zero coef", 24'h123456, zero_coef)
        wr(1'b1, 16, 24'hffffff);
        rd(1'b1, 24);
        `CHK("zero short", 24'h123456, q)
        wr(1'b0, 24, 24'he20000);
        wr(1'b1, 24, 24'h654321);
        rd(1'b1, 24);
        `CHK("full read", 24'h654321, q)
        `CHK("full coef", 24'h654321, full_coef)
        wr(1'b0, 24, 24'he00000);
        rd(1'b1, 24);
        `CHK("full ch0", 24'h800000, q)
        $display("test coef done");
    endtask : t_coef
    task automatic t_conv;
        wr(1'b0, 24, 24'h000123);
        eng(1'b0, 24'habcdef);
        `CHK("ready low", 1'b0, ready_n)
        rd(1'b1, 16);
        `CHK("data", 16'habcd, q[15:0])
        `CHK("ready high", 1'b1, ready_n)
        $display("test conv done");
    endtask : t_conv
    task automatic t_cal;
        wr(1'b0, 24, 24'h220000);
        `CHK("self src", 2'b11, {cal_on, cal_int})
        `CHK("cal chan", 1'b1, cal_ch)
        eng(1'b0, 24'h0000aa);
        `CHK("cal hide", 1'b1, ready_n)
        eng(1'b1, 24'h000111);
        `CHK("self full", 1'b1, cal_full)
        eng(1'b1, 24'h7fff00);
        `CHK("self mode", AMCC_MODE_NORMAL, mode)
        `CHK("self coefs", 48'h0001117fff00, {zero_coef, full_coef})
        eng(1'b0, 24'h345678);
        `CHK("self ready", 1'b0, ready_n)
        for (int m = 2; m < 5; m++)
        begin
            k = 0;
            wr(1'b0, 24, {m[2:0], 21'h000000});
            for (int j = 0; j < 3; j++)
                if (cal_on === 1'b1)
                begin
                    eng(1'b1, 24'h000100);
                    k++;
                end
            `CHK("steps", (m == 4) ? 2 : 1, k)
            `CHK("sys mode", AMCC_MODE_NORMAL, mode)
        end
        $display("test cal done");
    endtask : t_cal
    task automatic t_bg;
        wr(1'b0, 24, 24'ha00000);
        for (int j = 0; j < 5; j++)
            eng(cal_on, 24'h100000 + j);
        `CHK("bg hold", 1'b1, ready_n)
        eng(cal_on, 24'h100005);
        `CHK("bg ready", 1'b0, ready_n)
        `CHK("bg mode", AMCC_MODE_BACKGROUND, mode)
        `CHK("bg coefs", 48'h100000100001, {zero_coef, full_coef})
        $display("test bg done");
    endtask : t_bg
    initial
    begin
        #500000;
        bad_count++;
        summarize();
    end
    initial
    begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("ready reset", 1'b1, ready_n)
        t_ctrl();
        t_coef();
        t_conv();
        t_cal();
        t_bg();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
